// file: hdl/tcg_pkg.sv
package tcg_pkg;
  localparam logic [7:0] TCG_OFS_COUNT = 8'h00;
  localparam logic [7:0] TCG_OFS_LIMIT = 8'h04;
  localparam logic [7:0] TCG_OFS_CAPT = 8'h08;
  localparam logic [7:0] TCG_OFS_INT = 8'h0C;
  localparam logic [7:0] TCG_OFS_CTRL = 8'h10;
  localparam int TCG_MODE_LSB = 0;
  localparam int TCG_DIV_LSB = 3;
  localparam int TCG_POL_BIT = 6;
  localparam int TCG_EN_BIT = 7;
  localparam int TCG_DIVH_BIT = 8;
  localparam int TCG_OUTEN_BIT = 13;
  localparam int TCG_IRQEN_BIT = 14;
  localparam logic [2:0] TCG_MODE_CAPT = 3'h4;
  localparam logic [2:0] TCG_MODE_CMP = 3'h5;
  localparam logic [2:0] TCG_MODE_GATE = 3'h6;
  localparam logic [2:0] TCG_MODE_CC = 3'h7;
  localparam logic [31:0] TCG_RELOAD = 32'h0000_0001;
  localparam logic [31:0] TCG_ZERO = 32'h0000_0000;
  localparam logic [31:0] TCG_ALL_ONES = 32'hFFFF_FFFF;
  localparam int TCG_DIV_W = 4;

  typedef struct packed {
    logic irq_en;
    logic out_en;
    logic enable;
    logic pol;
    logic [3:0] div;
    logic [2:0] mode;
  } tcg_ctrl_t;

  localparam tcg_ctrl_t TCG_CTRL_RST = '0;
endpackage : tcg_pkg

// file: hdl/tcg_prescale.sv
module tcg_prescale
  import tcg_pkg::*;
#(
  parameter int DIV_W = TCG_DIV_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  localparam int CW = (1 << DIV_W);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] lim;

  // divide by two to the power of the divider value
  assign lim = (CW'(1) << div_i) - CW'(1);
  assign tick_o = run_i && (cnt_q >= lim);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (!run_i || tick_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : tcg_prescale

// file: hdl/tcg_timer.sv
module tcg_timer
  import tcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic irq_o
);
  tcg_ctrl_t ctrl_q;
  logic [31:0] count_q;
  logic [31:0] limit_q;
  logic [31:0] capt_q;
  logic flag_q;
  logic pin_out_q;
  logic armed_q;
  logic edge_pend_q;
  logic [2:0] sync_q;
  logic level_q;

  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic wr_count;
  logic wr_limit;
  logic wr_int;
  logic wr_ctrl;
  logic [7:0] ofs;

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;
  assign ofs = haddr_i[7:0];
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite_i;
      wr_addr_q <= ofs;
    end
  end

  assign wr_count = wr_pend_q && (wr_addr_q == TCG_OFS_COUNT);
  assign wr_limit = wr_pend_q && (wr_addr_q == TCG_OFS_LIMIT);
  assign wr_int = wr_pend_q && (wr_addr_q == TCG_OFS_INT);
  assign wr_ctrl = wr_pend_q && (wr_addr_q == TCG_OFS_CTRL);

  // read data is sampled in the address phase, unmapped reads give zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      unique case (ofs)
        TCG_OFS_COUNT: rdata_q <= count_q;
        TCG_OFS_LIMIT: rdata_q <= limit_q;
        TCG_OFS_CAPT: rdata_q <= capt_q;
        TCG_OFS_INT: rdata_q <= {31'h0000_0000, flag_q};
        TCG_OFS_CTRL: rdata_q <= {17'h0_0000, ctrl_q.irq_en, ctrl_q.out_en, 4'h0,
                                  ctrl_q.div[3], ctrl_q.enable, ctrl_q.pol,
                                  ctrl_q.div[2:0], ctrl_q.mode};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= TCG_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q.mode <= hwdata_i[TCG_MODE_LSB +: 3];
      ctrl_q.div <= {hwdata_i[TCG_DIVH_BIT], hwdata_i[TCG_DIV_LSB +: 3]};
      ctrl_q.pol <= hwdata_i[TCG_POL_BIT];
      ctrl_q.enable <= hwdata_i[TCG_EN_BIT];
      ctrl_q.out_en <= hwdata_i[TCG_OUTEN_BIT];
      ctrl_q.irq_en <= hwdata_i[TCG_IRQEN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      limit_q <= 32'h0000_0000;
    end else if (wr_limit) begin
      limit_q <= hwdata_i;
    end
  end

  // timer tick from the prescaler
  logic tick;
  logic run;
  assign run = ctrl_q.enable;

  tcg_prescale #(
    .DIV_W(TCG_DIV_W)
  ) u_prescale (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .div_i(ctrl_q.div),
    .tick_o(tick)
  );

  // pin synchroniser: a change counts once the second and third stages agree
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end

  logic stable;
  logic rise;
  logic fall;
  logic sel_edge;
  logic active;
  assign stable = (sync_q[1] == sync_q[2]);
  assign rise = stable && sync_q[2] && !level_q;
  assign fall = stable && !sync_q[2] && level_q;
  assign sel_edge = ctrl_q.pol ? fall : rise;
  assign active = level_q ^ ctrl_q.pol;

  logic is_capt;
  logic is_cmp;
  logic is_gate;
  logic is_cc;
  logic edge_mode;
  assign is_capt = (ctrl_q.mode == TCG_MODE_CAPT);
  assign is_cmp = (ctrl_q.mode == TCG_MODE_CMP);
  assign is_gate = (ctrl_q.mode == TCG_MODE_GATE);
  assign is_cc = (ctrl_q.mode == TCG_MODE_CC);
  assign edge_mode = is_capt || is_cc;

  // an edge waits for the next timer tick
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_pend_q <= 1'b0;
    end else if (!run || !edge_mode) begin
      edge_pend_q <= 1'b0;
    end else if (sel_edge) begin
      edge_pend_q <= 1'b1;
    end else if (tick) begin
      edge_pend_q <= 1'b0;
    end
  end

  logic step;
  logic match;
  logic do_capt;
  logic do_reload;
  logic do_arm;
  logic period_end;
  assign step = run && tick;
  assign match = (count_q == limit_q);
  assign do_arm = step && is_cc && !armed_q && edge_pend_q;
  assign do_capt = step && edge_pend_q && (is_capt || (is_cc && armed_q));
  assign do_reload = do_capt
                     || (step && match && (is_capt || (is_cc && armed_q)))
                     || (step && is_gate && active && match);
  assign period_end = do_reload || (step && is_cmp && match);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (!run || !is_cc) begin
      armed_q <= 1'b0;
    end else if (do_arm) begin
      armed_q <= 1'b1;
    end
  end

  // software writes win over counting; reloaded periods restart from one, compare mode counts on past the limit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 32'h0000_0000;
    end else if (wr_count) begin
      count_q <= hwdata_i;
    end else if (do_reload) begin
      count_q <= TCG_RELOAD;
    end else if (step) begin
      if (is_cmp) begin
        count_q <= count_q + 32'h0000_0001;
      end else if (is_capt || (is_cc && armed_q)) begin
        count_q <= count_q + 32'h0000_0001;
      end else if (is_gate && active) begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capt_q <= 32'h0000_0000;
    end else if (do_capt) begin
      capt_q <= count_q;
    end
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (period_end) begin
      flag_q <= 1'b1;
    end else if (wr_int) begin
      flag_q <= 1'b0;
    end
  end

  assign irq_o = flag_q && ctrl_q.irq_en;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_q <= 1'b0;
    end else if (!run) begin
      pin_out_q <= ctrl_q.pol;
    end else if (step && is_cmp && match && ctrl_q.out_en) begin
      pin_out_q <= !pin_out_q;
    end
  end

  assign pin_o = pin_out_q;
  assign pin_oe_o = is_cmp && ctrl_q.out_en;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_capt_copy;
    (step && is_capt && edge_pend_q && !wr_count)
      |=> (capt_q == $past(count_q)) && (count_q == TCG_RELOAD) && flag_q;
  endproperty
  a_capt_copy: assert property (p_capt_copy) else $error("capture failed");

  property p_capt_timeout;
    (step && is_capt && !edge_pend_q && match && !wr_count)
      |=> (count_q == TCG_RELOAD) && flag_q;
  endproperty
  a_capt_timeout: assert property (p_capt_timeout) else $error("timeout reload failed");

  property p_cmp_wrap;
    (step && is_cmp && (count_q == TCG_ALL_ONES) && !wr_count) |=> (count_q == TCG_ZERO);
  endproperty
  a_cmp_wrap: assert property (p_cmp_wrap) else $error("compare wrap failed");

  property p_cmp_match;
    (step && is_cmp && match && !wr_count && count_q != TCG_ALL_ONES)
      |=> flag_q && (count_q == $past(count_q) + 32'h0000_0001);
  endproperty
  a_cmp_match: assert property (p_cmp_match) else $error("compare match wrong");

  property p_cmp_toggle;
    (step && is_cmp && match && ctrl_q.out_en) |=> (pin_o != $past(pin_o));
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("pin did not toggle");

  property p_gate_hold;
    (is_gate && run && !active && !wr_count) |=> $stable(count_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");

  property p_cc_first;
    (is_cc && run && !armed_q && !wr_count && !wr_int) |=> $stable(count_q) && $stable(flag_q);
  endproperty
  a_cc_first: assert property (p_cc_first) else $error("unarmed counter moved");

  property p_int_clear;
    (wr_int && !period_end) |=> !flag_q ##1 (flag_q == $past(period_end));
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("flag clear failed");

  property p_disabled;
    (!run && !wr_count) |=> $stable(count_q) && $stable(capt_q) && !$rose(flag_q);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled timer changed");

  property p_irq;
    (period_end && ctrl_q.irq_en && !wr_ctrl) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  // capture/compare events: the first edge arms the counter, later edges capture and reload it
  property p_cc_capt;
    (step && is_cc && armed_q && edge_pend_q && !wr_count)
      |=> (capt_q == $past(count_q)) && (count_q == TCG_RELOAD) && flag_q;
  endproperty
  a_cc_capt: assert property (p_cc_capt) else $error("cc capture failed");

  property p_cc_timeout;
    (step && is_cc && armed_q && !edge_pend_q && match && !wr_count)
      |=> (count_q == TCG_RELOAD) && flag_q;
  endproperty
  a_cc_timeout: assert property (p_cc_timeout) else $error("cc timeout failed");

  property p_cc_arm;
    (step && is_cc && !armed_q && edge_pend_q && !wr_count && !wr_int)
      |=> armed_q && $stable(count_q) && $stable(flag_q);
  endproperty
  a_cc_arm: assert property (p_cc_arm) else $error("first edge handled wrong");

  property p_gate_end;
    (step && is_gate && active && match && !wr_count) |=> (count_q == TCG_RELOAD) && flag_q;
  endproperty
  a_gate_end: assert property (p_gate_end) else $error("gated reload failed");

  property p_capt_stay;
    (do_capt && !wr_ctrl) |=> run;
  endproperty
  a_capt_stay: assert property (p_capt_stay) else $error("timer stopped");

  // the count only moves on a divider tick or a software write
  property p_tick_only;
    (run && !tick && !wr_count) |=> $stable(count_q);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved off tick");

  c_capture: cover property (do_capt && is_capt);
  c_cc_arm: cover property (do_arm ##[1:1000] do_capt);
  c_gate_end: cover property (step && is_gate && active && match);
  c_cmp_toggle: cover property (step && is_cmp && match && ctrl_q.out_en);
  c_cc_timeout: cover property (step && is_cc && armed_q && match && !edge_pend_q);
endmodule : tcg_timer

// file: bench/tcg_pin_model.sv
module tcg_pin_model (
  input wire logic ref_clk_i,
  input wire logic lvl_i,
  input wire logic oe_i,
  input wire logic drv_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lvl_q;
  // external source changes its level just after a clock edge
  always_ff @(posedge ref_clk_i) begin
    lvl_q <= lvl_i;
  end
  // the source lets go of the wire while the timer drives it
  assign pin_o = oe_i ? drv_i : lvl_q;
endmodule : tcg_pin_model

// file: bench/tb_timer_capture_compare_gated_modes.sv
module tb_timer_capture_compare_gated_modes
  import tcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic lvl = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rdv;
  logic [31:0] keep;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin, pin_drv, pin_oe, irq;
  int n_fail = 0;
  int check_count = 0;

  always #50 ref_clk = ~ref_clk;

  tcg_timer DUT (.ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .pin_i(pin), .pin_o(pin_drv), .pin_oe_o(pin_oe), .irq_o(irq));
  tcg_pin_model PIN (.ref_clk_i(ref_clk), .lvl_i(lvl), .oe_i(pin_oe), .drv_i(pin_drv),
    .pin_o(pin));

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h0000_0001);
  endtask : rng

  task ack;
    int i;
    i = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_fail++;
        end_sim;
      end
      @(posedge ref_clk);
    end
  endtask : ack

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    ack;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ack;
    rdv = hrdata;
  endtask : xfer

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task wirq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1) begin
      if (i >= n) begin
        n_fail++;
        end_sim;
      end
      i++;
      @(posedge ref_clk);
    end
  endtask : wirq

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [3:0] dv,
      input logic p, input logic en);
    return {17'h0_0000, 2'b11, 4'h0, dv[3], en, p, dv[2:0], m};
  endfunction : ctl

  // disable, configure, then enable
  task cfg(input logic [2:0] m, input logic [3:0] dv, input logic p, input logic [31:0] c,
      input logic [31:0] l);
    xfer(TCG_OFS_CTRL, 1'b1, ctl(m, dv, p, 1'b0));
    xfer(TCG_OFS_COUNT, 1'b1, c);
    xfer(TCG_OFS_LIMIT, 1'b1, l);
    xfer(TCG_OFS_INT, 1'b1, 32'h0000_0000);
    xfer(TCG_OFS_CTRL, 1'b1, ctl(m, dv, p, 1'b1));
  endtask : cfg

  initial begin
    cyc(12);
    rst <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      xfer(8'(a), 1'b0, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
    end
    xfer(TCG_OFS_CAPT, 1'b1, 32'h1234_5678);
    xfer(TCG_OFS_CAPT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    xfer(TCG_OFS_CTRL, 1'b1, 32'hFFFF_FF7F);
    xfer(TCG_OFS_CTRL, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_617F);
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    xfer(TCG_OFS_COUNT, 1'b1, 32'h0000_0005);
    cyc(10);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0005);
    $display("test registers done");
    cfg(TCG_MODE_CMP, 4'h0, 1'b0, 32'h0000_0001, 32'h0000_0003);
    wirq(40);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({30'h0, pin_oe, pin_drv}, 32'h0000_0003);
    cyc(20);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0010, 32'h0000_0030);
    cfg(TCG_MODE_CMP, 4'h0, 1'b0, 32'hFFFF_FFFD, 32'h0000_0100);
    cyc(12);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0000, 32'h0000_0010);
    $display("test compare done");
    cfg(TCG_MODE_CAPT, 4'h0, 1'b0, 32'h0000_0001, 32'h0000_1000);
    cyc(30);
    lvl <= 1'b1;
    wirq(20);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(TCG_OFS_CAPT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_001E, 32'h0000_002D);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0001, 32'h0000_0010);
    xfer(TCG_OFS_INT, 1'b1, 32'hFFFF_FFFF);
    lvl <= 1'b0;
    cyc(10);
    xfer(TCG_OFS_INT, 1'b0, 32'h0000_0000);
    chk({rdv[31:1], irq}, 32'h0000_0000);
    xfer(TCG_OFS_CTRL, 1'b0, 32'h0000_0000);
    chk({31'h0, rdv[TCG_EN_BIT]}, 32'h0000_0001);
    cfg(TCG_MODE_CAPT, 4'h0, 1'b0, 32'h0000_0001, 32'h0000_0005);
    cyc(30);
    xfer(TCG_OFS_INT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0001);
    xfer(TCG_OFS_CTRL, 1'b1, ctl(TCG_MODE_CAPT, 4'h0, 1'b0, 1'b0) & 32'hFFFF_BFFF);
    cyc(1);
    chk({31'h0, irq}, 32'h0000_0000);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0001, 32'h0000_0005);
    $display("test capture done");
    cfg(TCG_MODE_GATE, 4'h0, 1'b0, 32'h0000_0007, 32'h0000_0014);
    cyc(20);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0007);
    lvl <= 1'b1;
    cyc(60);
    xfer(TCG_OFS_INT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0001);
    lvl <= 1'b0;
    cyc(8);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0001, 32'h0000_0014);
    keep = rdv;
    cyc(20);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    chk(rdv, keep);
    $display("test gated done");
    lvl <= 1'b1;
    cfg(TCG_MODE_CC, 4'h0, 1'b1, 32'h0000_0009, 32'h0000_0080);
    cyc(20);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0009);
    lvl <= 1'b0;
    cyc(20);
    xfer(TCG_OFS_INT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    lvl <= 1'b1;
    cyc(10);
    xfer(TCG_OFS_INT, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    lvl <= 1'b0;
    wirq(20);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(TCG_OFS_CAPT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0014, 32'h0000_007F);
    xfer(TCG_OFS_INT, 1'b1, 32'h0000_0000);
    wirq(200);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test capture compare done");
    cfg(TCG_MODE_CMP, 4'h3, 1'b0, 32'h0000_0000, 32'h0001_0000);
    cyc(80);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0008, 32'h0000_000C);
    cfg(TCG_MODE_CMP, 4'h8, 1'b0, 32'h0000_0000, 32'h0001_0000);
    cyc(600);
    xfer(TCG_OFS_COUNT, 1'b0, 32'h0000_0000);
    rng(rdv, 32'h0000_0001, 32'h0000_0003);
    $display("test divider done");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    xfer(TCG_OFS_CTRL, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    chk({30'h0, pin_oe, irq}, 32'h0000_0000);
    $display("test reset done");
    end_sim;
  end
endmodule : tb_timer_capture_compare_gated_modes
